// File: dv/raster_display_controller_test.sv
// self-checking bench for the raster display controller
module raster_display_controller_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, reset_n = 1'b0, func_strobe = 1'b0, block_strobe = 1'b0;
  logic yield_strobe = 1'b0, reg_write = 1'b0, reg_read = 1'b0, clear = 1'b0, even_exp = 1'b0;
  logic [2:0] func_task = 3'h0, block_task = 3'h0, yield_task = 3'h0, wake_grant;
  logic [3:0] func_code = 4'h0, reg_addr = 4'h0;
  logic [15:0] proc_bus = 16'h0000, reg_wdata = 16'h0000, reg_rdata;
  logic bit_clock_pin, next_bit9, wake_vertical, wake_horizontal, wake_word;
  logic video_out, hsync_out, vsync_out, n9;
  int lit_count, failures = 0, checked = 0, cycles = 0;
  always #10 clk = ~clk;
  always @(posedge vsync_out)
    even_exp <= ~even_exp;
  raster_display_controller #(.LINE_CYCLES(200), .HRETRACE_CYCLES(40), .FIELD_LINES(8),
    .VRETRACE_LINES(2)) dut (.clk(clk), .reset_n(reset_n), .bit_clock_pin(bit_clock_pin),
    .func_strobe(func_strobe), .func_task(func_task), .func_code(func_code),
    .proc_bus(proc_bus), .block_strobe(block_strobe), .block_task(block_task),
    .yield_strobe(yield_strobe), .yield_task(yield_task), .next_bit9(next_bit9),
    .wake_vertical(wake_vertical), .wake_horizontal(wake_horizontal), .wake_word(wake_word),
    .wake_grant(wake_grant), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .video_out(video_out), .hsync_out(hsync_out), .vsync_out(vsync_out));
  raster_monitor_model monitor (.clk(clk), .video_out(video_out), .clear(clear),
    .bit_clock_pin(bit_clock_pin), .lit_count(lit_count));
  // ****
  // compare and bus tasks
  // ****
  task automatic finish_test;
    $display("failures=%0d checked=%0d", failures, checked);
    if (failures == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_word({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic tick;
    @(posedge clk);
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    tick;
    reg_write <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, input logic [15:0] mask, input logic [15:0] exp);
    reg_addr <= a;
    reg_read <= 1'b1;
    tick;
    reg_read <= 1'b0;
    #1;
    cmp_word(reg_rdata & mask, exp);
    tick;
  endtask
  task automatic func(input logic [2:0] t, input logic [3:0] c, input logic [15:0] d);
    func_strobe <= 1'b1;
    func_task <= t;
    func_code <= c;
    proc_bus <= d;
    #5;
    n9 = next_bit9;
    tick;
    func_strobe <= 1'b0;
    tick;
  endtask
  // the block/yield strobe task returns 1 ns after the edge so wakeups can be judged
  task automatic sched(input bit y, input logic [2:0] t);
    block_strobe <= !y;
    yield_strobe <= y;
    block_task <= t;
    yield_task <= t;
    tick;
    block_strobe <= 1'b0;
    yield_strobe <= 1'b0;
    #1;
  endtask
  task automatic wait_rise(input bit v);
    logic [1:0] h;
    h = 2'b11;
    for (int i = 0; i < 2000 && h !== 2'b01; i++)
    begin
      @(negedge clk);
      h = {h[0], v ? vsync_out : hsync_out};
    end
    tick;
    if (h !== 2'b01)
      cmp_bit(1'b0, 1'b1);
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      finish_test;
    end
  end
  // ****
  // scenarios
  // ****
  task automatic t_reset;
    #1;
    cmp_bit(wake_vertical, 1'b1);
    cmp_bit(wake_word, 1'b1);
    cmp_word({13'h0000, wake_grant}, 16'h0001);
    tick;
    reg_rd(display_pkg::REG_STATUS, 16'h03df, 16'h0000);
    reg_rd(display_pkg::REG_CURSOR_X, 16'hffff, 16'hffff);
    reg_rd(display_pkg::REG_CURSOR_PATTERN, 16'hffff, 16'h0000);
    reg_wr(display_pkg::REG_CURSOR_PATTERN, 16'ha5a5);
    reg_rd(display_pkg::REG_CURSOR_PATTERN, 16'hffff, 16'ha5a5);
    reg_rd(4'hf, 16'hffff, 16'h0000);
  endtask
  task automatic t_mode;
    func(3'b001, display_pkg::FUNC_FIELD_TEST, 16'h0000);
    cmp_bit(n9, 1'b1);
    func(3'b010, display_pkg::FUNC_SET_MODE, 16'hc000);
    cmp_bit(n9, 1'b1);
    func(3'b100, display_pkg::FUNC_SET_MODE, 16'h0000);
    cmp_bit(n9, 1'b0);
    reg_rd(display_pkg::REG_STATUS, 16'h0080, 16'h0080);
    wait_rise(1'b0);
    repeat (2) tick;
    reg_rd(display_pkg::REG_STATUS, 16'h0040, 16'h0040);
    func(3'b010, display_pkg::FUNC_SET_MODE, 16'h0000);
    cmp_bit(n9, 1'b0);
    reg_rd(display_pkg::REG_STATUS, 16'h0080, 16'h0000);
  endtask
  // seventeen loads fill it whether or not the shifter took the first
  task automatic t_buffer;
    wait_rise(1'b0);
    for (int i = 0; i < 17; i++)
      func(3'b100, display_pkg::FUNC_BUFFER_LOAD, 16'h0000);
    cmp_bit(n9, 1'b0);
    #1;
    cmp_bit(wake_word, 1'b0);
    tick;
    reg_rd(display_pkg::REG_STATUS, 16'h001f, 16'h0010);
    sched(1'b0, 3'b100);
    wait_rise(1'b0);
    repeat (2) tick;
    #1;
    cmp_bit(wake_word, 1'b1);
    tick;
    reg_rd(display_pkg::REG_STATUS, 16'h011f, 16'h0000);
  endtask
  task automatic t_block;
    sched(1'b1, 3'b001);
    cmp_bit(wake_vertical, 1'b0);
    tick;
    sched(1'b0, 3'b100);
    cmp_bit(wake_word, 1'b0);
    cmp_word({13'h0000, wake_grant}, 16'h0002);
    tick;
    sched(1'b0, 3'b010);
    cmp_bit(wake_horizontal, 1'b0);
    wait_rise(1'b0);
    repeat (2) tick;
    #1;
    cmp_bit(wake_word, 1'b0);
    wait_rise(1'b1);
    repeat (2) tick;
    #1;
    cmp_word({13'h0000, wake_grant}, 16'h0001);
    cmp_bit(wake_horizontal, 1'b1);
    tick;
    func(3'b010, display_pkg::FUNC_FIELD_TEST, 16'h0000);
    cmp_bit(n9, even_exp);
    sched(1'b1, 3'b001);
    cmp_word({13'h0000, wake_grant}, 16'h0002);
    tick;
  endtask
  task automatic t_cursor;
    reg_wr(display_pkg::REG_CURSOR_PATTERN, 16'hffff);
    wait_rise(1'b1);
    repeat (2) wait_rise(1'b0);
    clear <= 1'b1;
    tick;
    clear <= 1'b0;
    wait_rise(1'b0);
    cmp_bit(lit_count == 0, 1'b1);
    reg_wr(display_pkg::REG_CURSOR_X, 16'h0002);
    wait_rise(1'b0);
    clear <= 1'b1;
    tick;
    clear <= 1'b0;
    wait_rise(1'b0);
    cmp_bit(lit_count >= 120 && lit_count <= 136, 1'b1);
  endtask
  initial
  begin
    repeat (5) tick;
    reset_n <= 1'b1;
    tick;
    t_reset;
    t_mode;
    t_buffer;
    t_block;
    t_cursor;
    finish_test;
  end
endmodule

// File: dv/raster_display_props.sv
// port checker for the raster display controller
module raster_display_props (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic func_strobe,
  input wire logic [2:0] func_task,
  input wire logic [3:0] func_code,
  input wire logic [15:0] proc_bus,
  input wire logic block_strobe,
  input wire logic [2:0] block_task,
  input wire logic yield_strobe,
  input wire logic [2:0] yield_task,
  input wire logic next_bit9,
  input wire logic wake_vertical,
  input wire logic wake_horizontal,
  input wire logic wake_word,
  input wire logic [2:0] wake_grant
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  property p_wake_reset;
    $rose(reset_n) |-> wake_vertical && wake_word && wake_grant == 3'b001;
  endproperty
  a_wake_reset: assert property (p_wake_reset) else $error("bad wakeups after reset");
  property p_grant_vert;
    wake_vertical |-> wake_grant == 3'b001;
  endproperty
  a_grant_vert: assert property (p_grant_vert) else $error("vertical not first");
  property p_grant_horiz;
    !wake_vertical && wake_horizontal |-> wake_grant == 3'b010;
  endproperty
  a_grant_horiz: assert property (p_grant_horiz) else $error("horizontal not second");
  property p_word_block;
    block_strobe && block_task == 3'b100 |=> !wake_word;
  endproperty
  a_word_block: assert property (p_word_block) else $error("word wakes after block");
  property p_word_wakes_horiz;
    wake_word && block_strobe && block_task == 3'b100 && !yield_strobe |=> wake_horizontal;
  endproperty
  a_word_wakes_horiz: assert property (p_word_wakes_horiz) else $error("no horizontal wake");
  // three cycles, so a late re-arm of either request is also caught
  property p_horiz_block;
    block_strobe && block_task == 3'b010 |=> (!wake_horizontal && !wake_word) [*3];
  endproperty
  a_horiz_block: assert property (p_horiz_block) else $error("wakes after horiz block");
  property p_vert_yield;
    yield_strobe && yield_task == 3'b001 |=> !wake_vertical;
  endproperty
  a_vert_yield: assert property (p_vert_yield) else $error("vertical stays awake");
  property p_next9_mode;
    func_strobe && func_task == 3'b010 && func_code == display_pkg::FUNC_SET_MODE
      |-> next_bit9 == proc_bus[display_pkg::BUS_RATE_BIT];
  endproperty
  a_next9_mode: assert property (p_next9_mode) else $error("set mode next bit wrong");
  property p_next9_idle;
    !func_strobe |-> !next_bit9;
  endproperty
  a_next9_idle: assert property (p_next9_idle) else $error("next bit without function");
endmodule
bind raster_display_controller raster_display_props u_props (
  .clk(clk),
  .reset_n(reset_n),
  .func_strobe(func_strobe),
  .func_task(func_task),
  .func_code(func_code),
  .proc_bus(proc_bus),
  .block_strobe(block_strobe),
  .block_task(block_task),
  .yield_strobe(yield_strobe),
  .yield_task(yield_task),
  .next_bit9(next_bit9),
  .wake_vertical(wake_vertical),
  .wake_horizontal(wake_horizontal),
  .wake_word(wake_word),
  .wake_grant(wake_grant)
);

// File: dv/raster_monitor_model.sv
// raster monitor model: bit clock source and video light meter
module raster_monitor_model (
  input wire logic clk,
  input wire logic video_out,
  input wire logic clear,
  output logic bit_clock_pin,
  output int lit_count
);
  timeunit 1ns;
  timeprecision 1ps;
  // offset start keeps the bit clock out of step with clk
  initial
  begin
    bit_clock_pin = 1'b0;
    #7;
    forever #80 bit_clock_pin = ~bit_clock_pin;
  end
  always @(posedge clk)
  begin
    if (clear)
      lit_count <= 0;
    else if (video_out === 1'b1)
      lit_count <= lit_count + 1;
  end
endmodule

// File: logic/display_sync_gen.sv
// horizontal and vertical sync generator
module display_sync_gen #(
  parameter int LINE_CYCLES = display_pkg::LINE_CYCLES,
  parameter int HRETRACE_CYCLES = display_pkg::HRETRACE_CYCLES,
  parameter int FIELD_LINES = display_pkg::FIELD_LINES,
  parameter int VRETRACE_LINES = display_pkg::VRETRACE_LINES
) (
  input wire logic clk,
  input wire logic reset_n,
  sync_if.gen sync
);
  display_pkg::sync_state_type state_reg;
  logic [15:0] hcount_reg;
  logic [15:0] line_reg;
  logic field_even_reg;
  logic hretrace_start_reg;
  logic vretrace_start_reg;
  logic line_start_reg;
  logic line_end;
  logic field_end;

  assign line_end = (hcount_reg == 16'(LINE_CYCLES - 1));
  assign field_end = (line_reg == 16'(FIELD_LINES - 1));

  // ********************************
  // horizontal counter
  // ********************************
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hcount_reg <= 16'h0000;
      state_reg <= display_pkg::SYNC_RETRACE;
    end
    else
    begin
      hcount_reg <= line_end ? 16'h0000 : hcount_reg + 16'h0001;
      unique case (state_reg)
        display_pkg::SYNC_RETRACE:
        begin
          if (hcount_reg == 16'(HRETRACE_CYCLES - 1))
            state_reg <= display_pkg::SYNC_ACTIVE;
        end
        display_pkg::SYNC_ACTIVE:
        begin
          if (line_end)
            state_reg <= display_pkg::SYNC_RETRACE;
        end
      endcase
    end
  end

  // ********************************
  // vertical counter and field parity
  // ********************************
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      line_reg <= 16'h0000;
      field_even_reg <= 1'b1;
    end
    else if (line_end)
    begin
      line_reg <= field_end ? 16'h0000 : line_reg + 16'h0001;
      if (field_end)
        field_even_reg <= ~field_even_reg;
    end
  end

  // ********************************
  // event pulses
  // ********************************
  // reset starts in retrace so the first field opens right after release
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hretrace_start_reg <= 1'b0;
      vretrace_start_reg <= 1'b0;
      line_start_reg <= 1'b0;
    end
    else
    begin
      hretrace_start_reg <= line_end;
      vretrace_start_reg <= line_end && field_end;
      line_start_reg <= (state_reg == display_pkg::SYNC_RETRACE) &&
                        (hcount_reg == 16'(HRETRACE_CYCLES - 1));
    end
  end

  assign sync.hblank = (state_reg == display_pkg::SYNC_RETRACE);
  assign sync.vblank = (line_reg < 16'(VRETRACE_LINES));
  assign sync.field_even = field_even_reg;
  assign sync.hretrace_start = hretrace_start_reg;
  assign sync.vretrace_start = vretrace_start_reg;
  assign sync.line_start = line_start_reg;
endmodule

// File: logic/raster_display_controller.sv
// raster display controller: buffer, serializer, cursor and task wakeups

// Behaviour
// R1 - buffer-load function writes one bus word
// R2 - buffer carries words into bit-clock shifter
// R3 - bit clock stops in blanking; 50/100 ns
// R4 - set-mode bit 0: slow next line, next9
// R5 - set-mode bit 1 latches video polarity
// R6 - field test ORs next9 in even field
// R7 - vertical wakeup once at vertical retrace
// R8 - horizontal wakeup at field, word blocks
// R9 - horizontal block silences both until field
// R10 - word wakeup: unblocked, horizontal unblocked, not full
// R11 - horizontal retrace empties buffer, unblocks word
// R12 - priority vertical, horizontal, then word
// R13 - vertical task sets up field, yields
// R14 - horizontal follows link or blocks
// R15 - horizontal sets mode, tab, addresses
// R16 - word task sends tab zero words first
// R17 - word task fetches doublewords until line end
// R18 - 16x16 cursor merged, fixed size, polarity
// R19 - cursor line in shifter, counter starts
// R20 - cursor task loads x, pattern in retrace
// R21 - refresh task fetches pattern lines, coordinates
// R22 - cursor x of -1 hides cursor
// R23 - mode word: resolution, polarity, tab, count
// R24 - low resolution halves bit rate
// R25 - reset: empty, unblocked, fast, normal, vertical
module raster_display_controller #(
  parameter int LINE_CYCLES = display_pkg::LINE_CYCLES,
  parameter int HRETRACE_CYCLES = display_pkg::HRETRACE_CYCLES,
  parameter int FIELD_LINES = display_pkg::FIELD_LINES,
  parameter int VRETRACE_LINES = display_pkg::VRETRACE_LINES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic bit_clock_pin,
  input wire logic func_strobe,
  input wire logic [2:0] func_task,
  input wire logic [3:0] func_code,
  input wire logic [15:0] proc_bus,
  input wire logic block_strobe,
  input wire logic [2:0] block_task,
  input wire logic yield_strobe,
  input wire logic [2:0] yield_task,
  output logic next_bit9,
  output logic wake_vertical,
  output logic wake_horizontal,
  output logic wake_word,
  output logic [2:0] wake_grant,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  output logic video_out,
  output logic hsync_out,
  output logic vsync_out
);
  localparam int CW = $clog2(display_pkg::BUFFER_DEPTH + 1);
  localparam int PW = $clog2(display_pkg::BUFFER_DEPTH);
  localparam logic [CW-1:0] FULL_COUNT = CW'(display_pkg::BUFFER_DEPTH);
  localparam logic [4:0] WORD_BITS = 5'(display_pkg::WORD_W);

  sync_if sync ();

  display_sync_gen #(
    .LINE_CYCLES(LINE_CYCLES),
    .HRETRACE_CYCLES(HRETRACE_CYCLES),
    .FIELD_LINES(FIELD_LINES),
    .VRETRACE_LINES(VRETRACE_LINES)
  ) sync_gen (
    .clk(clk),
    .reset_n(reset_n),
    .sync(sync.gen)
  );

  function automatic logic func_hit(input logic [2:0] task_sel, input logic [3:0] code,
                                    input logic [2:0] want_task, input logic [3:0] want_code);
    func_hit = (task_sel == want_task) && (code == want_code);
  endfunction

  // ********************************
  // function decode
  // ********************************
  logic load_hit;
  logic set_mode_hit;
  logic field_test_hit;

  assign load_hit = func_strobe && func_hit(func_task, func_code,
                    display_pkg::TASK_WORD, display_pkg::FUNC_BUFFER_LOAD); // R1
  assign set_mode_hit = func_strobe && func_hit(func_task, func_code,
                        display_pkg::TASK_HORIZONTAL, display_pkg::FUNC_SET_MODE);
  assign field_test_hit = func_strobe &&
    (func_hit(func_task, func_code, display_pkg::TASK_HORIZONTAL,
              display_pkg::FUNC_FIELD_TEST) ||
     func_hit(func_task, func_code, display_pkg::TASK_VERTICAL,
              display_pkg::FUNC_FIELD_TEST));

  // next-address merge is combinational so it lands in the same microcycle
  assign next_bit9 = (set_mode_hit && proc_bus[display_pkg::BUS_RATE_BIT]) || // R4
                     (field_test_hit && sync.field_even); // R6

  // ********************************
  // mode and polarity
  // ********************************
  logic slow_pending_reg;
  logic slow_reg;
  logic polarity_reg;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      slow_pending_reg <= 1'b0; // R25
      slow_reg <= 1'b0;
      polarity_reg <= 1'b0;
    end
    else
    begin
      if (set_mode_hit)
      begin
        slow_pending_reg <= proc_bus[display_pkg::BUS_RATE_BIT]; // R4
        polarity_reg <= proc_bus[display_pkg::BUS_POLARITY_BIT]; // R5
      end
      // rate change waits for the line boundary so a line never mixes rates
      if (sync.hretrace_start)
        slow_reg <= slow_pending_reg; // R4 R24
    end
  end

  // ********************************
  // bit clock sampling
  // ********************************
  logic bclk_meta_reg;
  logic bclk_sync_reg;
  logic bclk_prev_reg;
  logic phase_reg;
  logic blank;
  logic raw_tick;
  logic video_tick;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bclk_meta_reg <= 1'b0;
      bclk_sync_reg <= 1'b0;
      bclk_prev_reg <= 1'b0;
    end
    else
    begin
      bclk_meta_reg <= bit_clock_pin;
      bclk_sync_reg <= bclk_meta_reg;
      bclk_prev_reg <= bclk_sync_reg;
    end
  end

  assign blank = sync.hblank || sync.vblank;
  assign raw_tick = bclk_sync_reg && !bclk_prev_reg && !blank; // R3

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      phase_reg <= 1'b0;
    else if (sync.hretrace_start)
      phase_reg <= 1'b0;
    else if (raw_tick)
      phase_reg <= ~phase_reg;
  end

  // slow mode uses every second edge, giving the doubled period
  assign video_tick = raw_tick && (!slow_reg || phase_reg); // R3 R24

  // ********************************
  // word buffer
  // ********************************
  logic [display_pkg::WORD_W-1:0] buffer_mem [display_pkg::BUFFER_DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic full;
  logic empty;
  logic push;
  logic pop;
  logic [display_pkg::WORD_W-1:0] shift_reg;
  logic [4:0] shift_left_reg;

  assign full = (count_reg == FULL_COUNT);
  assign empty = (count_reg == '0);
  // a load into a full buffer is dropped; the word task is never woken then
  assign push = load_hit && !full; // R1
  assign pop = !empty && (shift_left_reg == 5'h00) && !sync.hretrace_start; // R2

  always_ff @(posedge clk)
  begin
    if (push)
      buffer_mem[sync.hretrace_start ? '0 : wr_ptr_reg] <= proc_bus;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ptr_reg <= '0; // R25
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else if (sync.hretrace_start)
    begin
      // a word written in the clearing cycle is kept in slot zero
      wr_ptr_reg <= push ? PW'(1) : '0; // R11
      rd_ptr_reg <= '0;
      count_reg <= push ? CW'(1) : '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + PW'(1);
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + PW'(1);
      count_reg <= count_reg + CW'(push) - CW'(pop);
    end
  end

  // ********************************
  // serializer
  // ********************************
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      shift_reg <= '0;
      shift_left_reg <= 5'h00;
    end
    else if (sync.hretrace_start)
    begin
      shift_left_reg <= 5'h00;
    end
    else if (pop)
    begin
      shift_reg <= buffer_mem[rd_ptr_reg]; // R2
      shift_left_reg <= WORD_BITS;
    end
    else if (video_tick && shift_left_reg != 5'h00)
    begin
      shift_reg <= {shift_reg[display_pkg::WORD_W-2:0], 1'b0};
      shift_left_reg <= shift_left_reg - 5'h01;
    end
  end

  // ********************************
  // cursor
  // ********************************
  logic [15:0] cursor_x_reg;
  logic [15:0] cursor_pattern_reg;
  logic [15:0] cursor_shift_reg;
  logic [4:0] cursor_left_reg;
  logic [15:0] cursor_pos_reg;
  logic cursor_bit;

  // counts every edge, so the cursor keeps its size in both rates
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cursor_shift_reg <= '0;
      cursor_left_reg <= 5'h00;
      cursor_pos_reg <= '0;
    end
    else if (sync.hretrace_start)
    begin
      cursor_shift_reg <= cursor_pattern_reg; // R19
      cursor_left_reg <= 5'h00;
      cursor_pos_reg <= '0;
    end
    else if (raw_tick)
    begin
      cursor_pos_reg <= cursor_pos_reg + 16'h0001; // R19
      if (cursor_left_reg != 5'h00)
      begin
        cursor_shift_reg <= {cursor_shift_reg[14:0], 1'b0};
        cursor_left_reg <= cursor_left_reg - 5'h01;
      end
      else if (cursor_pos_reg == cursor_x_reg && cursor_x_reg != display_pkg::CURSOR_OFF)
        cursor_left_reg <= WORD_BITS; // R18 R22
    end
  end

  assign cursor_bit = (cursor_left_reg != 5'h00) && cursor_shift_reg[15];

  // ********************************
  // video and sync outputs
  // ********************************
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      video_out <= 1'b0;
      hsync_out <= 1'b0;
      vsync_out <= 1'b0;
    end
    else
    begin
      // cursor shares the block polarity, merged before inversion
      video_out <= !blank && ((((shift_left_reg != 5'h00) && shift_reg[15]) ||
                   cursor_bit) ^ polarity_reg); // R5 R18
      hsync_out <= sync.hblank;
      vsync_out <= sync.vblank;
    end
  end

  // ********************************
  // task wakeups
  // ********************************
  logic wake_vertical_reg;
  logic wake_horizontal_reg;
  logic horiz_blocked_reg;
  logic word_blocked_reg;
  logic word_block_hit;

  assign word_block_hit = block_strobe && (block_task == display_pkg::TASK_WORD);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      wake_vertical_reg <= 1'b1; // R25
    else if (sync.vretrace_start)
      wake_vertical_reg <= 1'b1; // R7
    else if ((yield_strobe && yield_task == display_pkg::TASK_VERTICAL) ||
             (block_strobe && block_task == display_pkg::TASK_VERTICAL))
      wake_vertical_reg <= 1'b0;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wake_horizontal_reg <= 1'b0;
      horiz_blocked_reg <= 1'b0; // R25
    end
    else if (sync.vretrace_start)
    begin
      wake_horizontal_reg <= 1'b1; // R8
      horiz_blocked_reg <= 1'b0;
    end
    else if (block_strobe && block_task == display_pkg::TASK_HORIZONTAL)
    begin
      wake_horizontal_reg <= 1'b0;
      horiz_blocked_reg <= 1'b1; // R9
    end
    else if (word_block_hit && !horiz_blocked_reg)
      wake_horizontal_reg <= 1'b1; // R8 R9
    else if (yield_strobe && yield_task == display_pkg::TASK_HORIZONTAL)
      wake_horizontal_reg <= 1'b0;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      word_blocked_reg <= 1'b0; // R25
    else if (word_block_hit)
      word_blocked_reg <= 1'b1;
    else if (sync.hretrace_start)
      word_blocked_reg <= 1'b0; // R11
  end

  assign wake_vertical = wake_vertical_reg; // R7
  assign wake_horizontal = wake_horizontal_reg && !horiz_blocked_reg; // R9
  assign wake_word = !word_blocked_reg && !horiz_blocked_reg && !full; // R10

  always_comb
  begin
    wake_grant = 3'b000;
    if (wake_vertical)
      wake_grant = display_pkg::TASK_VERTICAL; // R12
    else if (wake_horizontal)
      wake_grant = display_pkg::TASK_HORIZONTAL; // R12
    else if (wake_word)
      wake_grant = display_pkg::TASK_WORD; // R12
  end

  // ********************************
  // register port
  // ********************************
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cursor_x_reg <= display_pkg::CURSOR_X_RESET;
      cursor_pattern_reg <= display_pkg::CURSOR_PATTERN_RESET;
    end
    else if (reg_write)
    begin
      if (reg_addr == display_pkg::REG_CURSOR_X)
        cursor_x_reg <= reg_wdata; // R20
      if (reg_addr == display_pkg::REG_CURSOR_PATTERN)
        cursor_pattern_reg <= reg_wdata; // R20
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata <= 16'h0000;
    else if (reg_read)
    begin
      reg_rdata <= 16'h0000;
      unique case (reg_addr)
        display_pkg::REG_CURSOR_X: reg_rdata <= cursor_x_reg;
        display_pkg::REG_CURSOR_PATTERN: reg_rdata <= cursor_pattern_reg;
        display_pkg::REG_STATUS:
        begin
          reg_rdata[display_pkg::STAT_COUNT_LSB +: CW] <= count_reg;
          reg_rdata[display_pkg::STAT_FIELD_EVEN] <= sync.field_even;
          reg_rdata[display_pkg::STAT_SLOW] <= slow_reg;
          reg_rdata[display_pkg::STAT_POLARITY] <= polarity_reg;
          reg_rdata[display_pkg::STAT_WORD_BLOCKED] <= word_blocked_reg;
          reg_rdata[display_pkg::STAT_HORIZ_BLOCKED] <= horiz_blocked_reg;
          reg_rdata[display_pkg::STAT_HBLANK] <= sync.hblank;
          reg_rdata[display_pkg::STAT_VBLANK] <= sync.vblank;
        end
        default: reg_rdata <= 16'h0000;
      endcase
    end
    else
      reg_rdata <= 16'h0000;
  end
endmodule

// File: shared/display_pkg.sv
// constants and types shared by the raster display controller
package display_pkg;
  localparam int WORD_W = 16;
  localparam int BUFFER_DEPTH = 16;
  localparam int CLK_PERIOD_NS = 20;
  // ********************************
  // sync timing
  // ********************************
  localparam int HRETRACE_NS = 6000;
  localparam int HRETRACE_CYCLES = HRETRACE_NS / CLK_PERIOD_NS;
  localparam int LINE_NS = 38095;
  localparam int LINE_CYCLES = LINE_NS / CLK_PERIOD_NS;
  localparam int FIELD_LINES = 437;
  localparam int VRETRACE_LINES = 20;
  // ********************************
  // second function field codes
  // ********************************
  localparam logic [3:0] FUNC_BUFFER_LOAD = 4'h8;
  localparam logic [3:0] FUNC_SET_MODE = 4'h9;
  localparam logic [3:0] FUNC_FIELD_TEST = 4'h8;
  // processor bus bit 0 is the msb
  localparam int BUS_RATE_BIT = 15;
  localparam int BUS_POLARITY_BIT = 14;
  typedef enum logic [2:0] {
    TASK_VERTICAL = 3'b001,
    TASK_HORIZONTAL = 3'b010,
    TASK_WORD = 3'b100
  } task_sel_type;
  typedef enum logic [1:0] {
    SYNC_ACTIVE = 2'b01,
    SYNC_RETRACE = 2'b10
  } sync_state_type;
  // ********************************
  // register port
  // ********************************
  localparam logic [3:0] REG_CURSOR_X = 4'h0;
  localparam logic [3:0] REG_CURSOR_PATTERN = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;
  localparam logic [15:0] CURSOR_OFF = 16'hffff;
  localparam logic [15:0] CURSOR_X_RESET = 16'hffff;
  localparam logic [15:0] CURSOR_PATTERN_RESET = 16'h0000;
  localparam int STAT_COUNT_LSB = 0;
  localparam int STAT_FIELD_EVEN = 5;
  localparam int STAT_SLOW = 6;
  localparam int STAT_POLARITY = 7;
  localparam int STAT_WORD_BLOCKED = 8;
  localparam int STAT_HORIZ_BLOCKED = 9;
  localparam int STAT_HBLANK = 10;
  localparam int STAT_VBLANK = 11;
endpackage

// File: shared/sync_if.sv
// timing signals from the sync generator to the controller
interface sync_if;
  logic hblank;
  logic vblank;
  logic field_even;
  logic hretrace_start;
  logic vretrace_start;
  logic line_start;
  modport gen (
    output hblank,
    output vblank,
    output field_even,
    output hretrace_start,
    output vretrace_start,
    output line_start
  );
  modport user (
    input hblank,
    input vblank,
    input field_even,
    input hretrace_start,
    input vretrace_start,
    input line_start
  );
endinterface
